// File: cpu_core_model.sv
// cpu_core_model.sv: stands in for the cpu core reset and nmi inputs
// assumes one aclk domain and one-cycle command pulses from the bench.
`timescale 1ns/1ps
module cpu_core_model (
   input wire logic aclk,
   input wire logic cpu_reset_q,
   input wire logic cpu_nmi_q,
   input wire logic ext_reset_cmd,
   input wire logic ext_nmi_cmd,
   output logic foreign_reset,
   output logic foreign_nmi,
   output int reset_seen,
   output int nmi_seen
);
   // start quiet so the unit never sees an unknown event line
   initial begin
      foreign_reset = 1'b0;
      foreign_nmi = 1'b0;
      reset_seen = 0;
      nmi_seen = 0;
   end

   // count watchdog events; foreign events lag the request by one cycle
   always @(posedge aclk) begin
      reset_seen <= reset_seen + int'(cpu_reset_q);
      nmi_seen <= nmi_seen + int'(cpu_nmi_q);
      foreign_reset <= ext_reset_cmd;
      foreign_nmi <= ext_nmi_cmd;
   end
endmodule

// File: timeout_counter.sv
// timeout_counter.sv: counts selected clock ticks and flags the timeout
// assumes tick is a one-cycle pulse per edge of the selected count clock.
`timescale 1ns/1ps
module timeout_counter
   import watchdog_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic run,
   input wire logic tick,
   input wire logic restart,
   input wire count_t limit,
   output logic expired_q
);
   count_t count_q;

   // count only while running; restart and expiry both go back to zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= 28'h000_0000;
         expired_q <= 1'b0;
      end else if (ce) begin
         expired_q <= 1'b0;
         if (!run || restart) begin
            count_q <= 28'h000_0000;
         end else if (tick) begin
            if (count_q == limit - 28'h000_0001) begin
               count_q <= 28'h000_0000;
               expired_q <= 1'b1;
            end else begin
               count_q <= count_q + 28'h000_0001;
            end
         end
      end
   end
endmodule

// File: watchdog_cfg.svh
// watchdog_cfg.svh: offsets, field positions, reset values and timing counts
// for the watchdog unit; assumes inclusion by the package and design files.
`ifndef WATCHDOG_CFG_SVH
`define WATCHDOG_CFG_SVH

// printed offsets are register indices; byte address is four times the index
`define CTRL_INDEX 8'h93
`define KEY_INDEX 8'h94
`define CTRL_ADDR 12'h24C
`define KEY_ADDR 12'h250
`define STATUS_ADDR 12'h254
`define MASK_ADDR 12'h258
`define CAUSE_ADDR 12'h25C

// control field positions
`define EN_BIT 7
`define NMI_SEL_BIT 6
`define RST_FLAG_BIT 5
`define NMI_FLAG_BIT 4
`define CLK_SEL_HI 3
`define CLK_SEL_LO 2
`define LEN_SEL_HI 1
`define LEN_SEL_LO 0

// control reset value: clock select 10b, all else zero
`define CTRL_RESET 8'h08

// service key values
`define KEY_FIRST 8'hA5
`define KEY_SECOND 8'h5A

// timeout exponents: system clock, rtc source, rc oscillator
`define EXP_SYS_0 27
`define EXP_SYS_1 25
`define EXP_SYS_2 22
`define EXP_SYS_3 18
`define EXP_RTC_0 17
`define EXP_RTC_1 14
`define EXP_RTC_2 11
`define EXP_RTC_3 7
`define EXP_RC_0 15
`define EXP_RC_1 13
`define EXP_RC_2 9
`define EXP_RC_3 5

// axi response codes
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// File: watchdog_pkg.sv
// watchdog_pkg.sv: types shared by the watchdog unit files
// assumes watchdog_cfg.svh sits in the include path.
package watchdog_pkg;
`include "watchdog_cfg.svh"

   typedef enum logic [1:0] {
      SRC_SYS = 2'b00,
      SRC_RTC = 2'b01,
      SRC_RC = 2'b10,
      SRC_RSVD = 2'b11
   } count_clock_select_e;

   typedef struct packed {
      logic watchdog_enable_bit;
      logic nmi_select;
      logic reset_flag;
      logic nmi_flag;
      count_clock_select_e count_clock_select;
      logic [1:0] timeout_length_select;
   } watchdog_control_s;

   typedef enum logic [1:0] {
      KEY_IDLE = 2'b00,
      KEY_ARMED = 2'b01
   } key_state_e;

   typedef logic [27:0] count_t;
endpackage

// File: watchdog_unit.sv
// watchdog_unit.sv: watchdog with locked control, two-write service key,
// AXI4-Lite register slave and event interrupt.
// assumes rtc_tick and rc_tick are one-cycle pulses in the aclk domain and
// that the cpu reports foreign resets and non-watchdog nmis as pulses.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module watchdog_unit
   import watchdog_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic rtc_tick,
   input wire logic rc_tick,
   input wire logic foreign_reset,
   input wire logic foreign_nmi,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic cpu_reset_q,
   output logic cpu_nmi_q,
   output logic irq_q
);
   watchdog_control_s ctrl_q;
   key_state_e key_q;
   logic [1:0] status_q;
   logic [1:0] mask_q;
   logic [11:0] awaddr_q;
   logic aw_held_q;
   logic [7:0] wdata_q;
   logic w_held_q;
   logic wr_go;
   logic ctrl_wr;
   logic key_wr;
   logic mask_wr;
   logic status_rd;
   logic rd_go;
   logic service;
   logic expired;
   logic tick;
   logic timeout;
   logic [31:0] rdata_d;
   logic rd_ok;
   logic wr_ok;
   count_t limit;
   // every check below runs on aclk and sleeps through reset
   default clocking chk_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // timeout length from clock source and period code
   function automatic count_t limit_of(input count_clock_select_e src,
                                       input logic [1:0] len);
      int e;
      e = 0;
      case (src)
         SRC_SYS: begin
            case (len)
               2'b00: e = `EXP_SYS_0;
               2'b01: e = `EXP_SYS_1;
               2'b10: e = `EXP_SYS_2;
               default: e = `EXP_SYS_3;
            endcase
         end
         SRC_RTC: begin
            case (len)
               2'b00: e = `EXP_RTC_0;
               2'b01: e = `EXP_RTC_1;
               2'b10: e = `EXP_RTC_2;
               default: e = `EXP_RTC_3;
            endcase
         end
         SRC_RC: begin
            case (len)
               2'b00: e = `EXP_RC_0;
               2'b01: e = `EXP_RC_1;
               2'b10: e = `EXP_RC_2;
               default: e = `EXP_RC_3;
            endcase
         end
         default: e = `EXP_RC_0; // reserved code behaves as rc, longest
      endcase
      return count_t'(28'h000_0001 << e);
   endfunction

   // word-aligned address match, shared by read and write decode
   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      return a[11:2] == r[11:2];
   endfunction

   // select the count tick; reserved code holds the count still
   always_comb begin
      case (ctrl_q.count_clock_select)
         SRC_SYS: tick = 1'b1;
         SRC_RTC: tick = rtc_tick;
         SRC_RC: tick = rc_tick;
         default: tick = 1'b0;
      endcase
   end

   assign limit = limit_of(ctrl_q.count_clock_select,
                           ctrl_q.timeout_length_select);
   assign timeout = expired;

   timeout_counter u_counter (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .run(ctrl_q.watchdog_enable_bit),
      .tick(tick),
      .restart(service),
      .limit(limit),
      .expired_q(expired)
   );

   // write channel capture: address and data may come in either order
   assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
   assign ctrl_wr = wr_go && hit(awaddr_q, `CTRL_ADDR);
   assign key_wr = wr_go && hit(awaddr_q, `KEY_ADDR);
   assign mask_wr = wr_go && hit(awaddr_q, `MASK_ADDR);
   assign wr_ok = hit(awaddr_q, `CTRL_ADDR) || hit(awaddr_q, `KEY_ADDR)
                  || hit(awaddr_q, `MASK_ADDR);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 12'h000;
         wdata_q <= 8'h00;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else if (ce) begin
         s_axi_awready <= !aw_held_q && !s_axi_awready;
         s_axi_wready <= !w_held_q && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            // only byte lane 0 carries data; a write without it stores zero
            wdata_q <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // control register: writable only while disabled, flags hardware owned
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q.watchdog_enable_bit <= 1'b0;
         ctrl_q.nmi_select <= 1'b0;
         ctrl_q.count_clock_select <= SRC_RC;
         ctrl_q.timeout_length_select <= 2'b00;
      end else if (ce) begin
         if (ctrl_wr && !ctrl_q.watchdog_enable_bit) begin
            ctrl_q.watchdog_enable_bit <= wdata_q[`EN_BIT];
            ctrl_q.nmi_select <= wdata_q[`NMI_SEL_BIT];
            ctrl_q.count_clock_select <=
               count_clock_select_e'(wdata_q[`CLK_SEL_HI:`CLK_SEL_LO]);
            ctrl_q.timeout_length_select <=
               wdata_q[`LEN_SEL_HI:`LEN_SEL_LO];
         end
      end
   end

   // source flags; the watchdog reset must not clear its own flag, so the
   // reset flag lives outside aresetn and is cleared by foreign_reset only
   always_ff @(posedge aclk) begin
      if (ce) begin
         if (timeout && ctrl_q.watchdog_enable_bit && !ctrl_q.nmi_select) begin
            ctrl_q.reset_flag <= 1'b1;
         end else if (foreign_reset) begin
            ctrl_q.reset_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q.nmi_flag <= 1'b0;
      end else if (ce) begin
         if (timeout && ctrl_q.nmi_select) begin
            ctrl_q.nmi_flag <= 1'b1;
         end else if (foreign_nmi) begin
            ctrl_q.nmi_flag <= 1'b0;
         end
      end
   end

   // service key sequencer; any delay between writes is fine
   assign service = key_wr && key_q == KEY_ARMED
                    && wdata_q == `KEY_SECOND;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         key_q <= KEY_IDLE;
      end else if (ce && key_wr) begin
         case (key_q)
            KEY_IDLE: begin
               if (wdata_q == `KEY_FIRST) begin
                  key_q <= KEY_ARMED;
               end
            end
            KEY_ARMED: begin
               // a stray value drops the sequence, A5h re-arms it
               key_q <= (wdata_q == `KEY_FIRST) ? KEY_ARMED
                                                : KEY_IDLE;
            end
            default: key_q <= KEY_IDLE;
         endcase
      end
   end

   // timeout response to the cpu: one-cycle reset or nmi pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpu_reset_q <= 1'b0;
         cpu_nmi_q <= 1'b0;
      end else if (ce) begin
         cpu_reset_q <= timeout && !ctrl_q.nmi_select;
         cpu_nmi_q <= timeout && ctrl_q.nmi_select;
      end
   end

   // event status: bit0 reset timeout, bit1 nmi timeout; read clears,
   // but a new event in the same cycle wins over the clear
   assign status_rd = rd_go && hit(s_axi_araddr, `STATUS_ADDR);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_q <= 2'b00;
         mask_q <= 2'b00;
         irq_q <= 1'b0;
      end else if (ce) begin
         status_q <= (status_rd ? 2'b00 : status_q)
                     | {timeout && ctrl_q.nmi_select,
                        timeout && !ctrl_q.nmi_select};
         if (mask_wr) begin
            mask_q <= wdata_q[1:0];
         end
         irq_q <= |(status_q & mask_q);
      end
   end

   // read channel: one read at a time, data registered
   assign rd_go = s_axi_arvalid && s_axi_arready;
   assign rd_ok = hit(s_axi_araddr, `CTRL_ADDR)
                  || hit(s_axi_araddr, `STATUS_ADDR)
                  || hit(s_axi_araddr, `MASK_ADDR)
                  || hit(s_axi_araddr, `CAUSE_ADDR)
                  || hit(s_axi_araddr, `KEY_ADDR);

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (hit(s_axi_araddr, `CTRL_ADDR)) begin
         rdata_d[7:0] = ctrl_q;
      end else if (hit(s_axi_araddr, `STATUS_ADDR)) begin
         rdata_d[1:0] = status_q;
      end else if (hit(s_axi_araddr, `MASK_ADDR)) begin
         rdata_d[1:0] = mask_q;
      end else if (hit(s_axi_araddr, `CAUSE_ADDR)) begin
         rdata_d[0] = ctrl_q.watchdog_enable_bit;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (ce) begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (rd_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_d;
            s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // a set enable bit stays set until chip reset
   enable_sticky_a: assert property (
      ctrl_q.watchdog_enable_bit |=> ctrl_q.watchdog_enable_bit)
      else $error("enable bit dropped without reset");

   locked_ctrl_a: assert property (
      ctrl_q.watchdog_enable_bit |=> $stable(ctrl_q.nmi_select)
      && $stable(ctrl_q.count_clock_select)
      && $stable(ctrl_q.timeout_length_select))
      else $error("control changed while enabled");

   reset_pulse_a: assert property (
      ce && timeout && !ctrl_q.nmi_select |=> cpu_reset_q && !cpu_nmi_q)
      else $error("reset mode timeout gave no reset");
   nmi_pulse_a: assert property (
      ce && timeout && ctrl_q.nmi_select |=> cpu_nmi_q && !cpu_reset_q)
      else $error("nmi mode timeout gave no nmi");

   rst_flag_a: assert property (
      ce && timeout && !ctrl_q.nmi_select |=> ctrl_q.reset_flag)
      else $error("reset flag not set");
   nmi_flag_a: assert property (
      ce && foreign_nmi && !timeout |=> !ctrl_q.nmi_flag)
      else $error("foreign nmi left flag set");

   no_timeout_off_a: assert property (
      !ctrl_q.watchdog_enable_bit |-> !timeout)
      else $error("timeout while disabled");

   sequence key_pair_s;
      key_wr && ce && key_q == KEY_ARMED && wdata_q == `KEY_SECOND;
   endsequence
   key_service_a: assert property (
      key_pair_s |=> key_q == KEY_IDLE && !timeout)
      else $error("service did not restart count");

   key_discard_a: assert property (
      ce && key_wr && wdata_q != `KEY_SECOND && wdata_q != `KEY_FIRST
      |=> key_q == KEY_IDLE)
      else $error("bad key kept sequence armed");
endmodule

// File: watchdog_unit_tb_top.sv
// watchdog_unit_tb_top.sv: register-level bench for the watchdog unit
// assumes ticks every cycle on both count clocks and a 25 MHz aclk.
`timescale 1ns/1ps
`include "watchdog_cfg.svh"
module watchdog_unit_tb_top
   import watchdog_pkg::*;
;
   logic aclk, aresetn, ce, rtc_tick, rc_tick, rst_cmd, nmi_cmd;
   logic foreign_reset, foreign_nmi, cpu_reset_q, cpu_nmi_q, irq_q;
   logic [11:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, got;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   int reset_seen, nmi_seen, took, ts, r0;
   int cyc = 0;
   int miscompares = 0;
   int samples_checked = 0;
   logic [7:0] ctl_tab [7] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h85, 8'h86,
      8'h87};
   int exp_tab [7] = '{15, 13, 9, 5, 14, 11, 7};

   watchdog_unit watchdog_unit_inst (.aclk(aclk), .aresetn(aresetn),
      .ce(ce), .rtc_tick(rtc_tick), .rc_tick(rc_tick),
      .foreign_reset(foreign_reset), .foreign_nmi(foreign_nmi),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .cpu_reset_q(cpu_reset_q), .cpu_nmi_q(cpu_nmi_q), .irq_q(irq_q));

   cpu_core_model cpu_core_model_inst (.aclk(aclk),
      .cpu_reset_q(cpu_reset_q), .cpu_nmi_q(cpu_nmi_q),
      .ext_reset_cmd(rst_cmd), .ext_nmi_cmd(nmi_cmd),
      .foreign_reset(foreign_reset), .foreign_nmi(foreign_nmi),
      .reset_seen(reset_seen), .nmi_seen(nmi_seen));

   // free-running clock and cycle stamp for timeout measurement
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   always @(posedge aclk) cyc <= cyc + 1;

   task automatic wrap_up();
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic give_up(input string what);
      miscompares++;
      $display("Error %s expected response seen none", what);
      wrap_up();
   endtask

   task automatic check(input string what, input logic [31:0] exp,
         input logic [31:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic check_span(input string what, input int lo, input int hi,
         input int seen);
      samples_checked++;
      if (seen < lo || seen > hi) begin
         miscompares++;
         $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, seen);
      end
   endtask

   // axi write: address and data offered together, each dropped once taken
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (n == 64) give_up("write");
      resp = bresp;
      bready <= 1'b0;
   endtask

   // axi read: rready held until the data is seen
   task automatic rd(input logic [11:0] a);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (n == 64) give_up("read");
      got = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   task automatic chip_reset(input int n);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (n) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
   endtask

   // one-cycle foreign event request to the cpu model
   task automatic foreign(input logic nmi);
      @(posedge aclk);
      rst_cmd <= ~nmi;
      nmi_cmd <= nmi;
      @(posedge aclk);
      rst_cmd <= 1'b0;
      nmi_cmd <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask

   // wait for the next reset or nmi from the unit, cycles counted from t0
   task automatic wait_evt(input int t0, input int lim);
      int rs0;
      int ns0;
      rs0 = reset_seen;
      ns0 = nmi_seen;
      while (reset_seen == rs0 && nmi_seen == ns0) begin
         @(posedge aclk);
         if (cyc - t0 > lim) give_up("timeout event");
      end
      took = cyc - t0;
   endtask

   // enable with ctl and time the response; ticks arrive every cycle
   task automatic run_out(input logic [7:0] ctl, input int ticks);
      wr(`CTRL_ADDR, ctl);
      wait_evt(cyc, ticks + 64);
      check_span("timeout ticks", ticks - 2, ticks + 6, took);
   endtask

   initial begin
      aresetn = 1'b0;
      ce = 1'b1;
      rtc_tick = 1'b1;
      rc_tick = 1'b1;
      {rst_cmd, nmi_cmd, awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hF;
      chip_reset(16);
      // the reset flag is undefined until a foreign reset reaches it
      foreign(1'b0);
      rd(`CTRL_ADDR);
      check("control reset", 32'h0000_0008, got);
      rd(`CAUSE_ADDR);
      check("enable mirror", 32'h0000_0000, got);
      rd(`MASK_ADDR);
      check("mask reset", 32'h0000_0000, got);
      rd(`KEY_ADDR);
      check("key read", 32'h0000_0000, got);
      rd(12'h3F0);
      check("unmapped read", {30'h0, `RESP_SLVERR}, {30'h0, resp});
      wr(12'h3F0, 8'h55);
      check("unmapped write", {30'h0, `RESP_SLVERR}, {30'h0, resp});
      $display("test reset state done");

      // every period code on the rc source, three on the rtc source
      for (int i = 0; i < 7; i++) begin
         chip_reset(2);
         run_out(ctl_tab[i], 1 << exp_tab[i]);
      end
      wr(`CTRL_ADDR, 8'h00);
      check("locked write resp", {30'h0, `RESP_OKAY}, {30'h0, resp});
      rd(`CTRL_ADDR);
      check("locked control", 32'h0000_00A7, got);
      rd(`STATUS_ADDR);
      check("status reset", 32'h0000_0001, got);
      check("irq masked", 32'h0, {31'h0, irq_q});
      rd(`STATUS_ADDR);
      check("status cleared", 32'h0000_0000, got);
      chip_reset(2);
      rd(`CTRL_ADDR);
      check("flag kept", 32'h0000_0028, got);
      foreign(1'b0);
      rd(`CTRL_ADDR);
      check("flag cleared", 32'h0000_0008, got);
      $display("test timeout lengths done");

      // nmi response with its interrupt unmasked
      chip_reset(2);
      wr(`MASK_ADDR, 8'h02);
      r0 = reset_seen;
      run_out(8'hCA, 512);
      @(posedge aclk);
      check("irq raised", 32'h1, {31'h0, irq_q});
      check("no cpu reset", r0, reset_seen);
      rd(`CTRL_ADDR);
      check("nmi flag", 32'h0000_00DA, got);
      rd(`STATUS_ADDR);
      check("status nmi", 32'h0000_0002, got);
      repeat (3) @(posedge aclk);
      check("irq cleared", 32'h0, {31'h0, irq_q});
      foreign(1'b1);
      rd(`CTRL_ADDR);
      check("nmi flag cleared", 32'h0000_00CA, got);
      $display("test nmi done");

      // service key keeps a 512-tick watchdog quiet, with a slow second write
      chip_reset(2);
      wr(`CTRL_ADDR, 8'h8A);
      r0 = reset_seen;
      for (int k = 0; k < 3; k++) begin
         repeat (400) @(posedge aclk);
         wr(`KEY_ADDR, `KEY_FIRST);
         repeat (60) @(posedge aclk);
         wr(`KEY_ADDR, `KEY_SECOND);
      end
      ts = cyc;
      check("serviced", r0, reset_seen);
      repeat (300) @(posedge aclk);
      wr(`KEY_ADDR, `KEY_FIRST);
      wr(`KEY_ADDR, 8'h11);
      wr(`KEY_ADDR, `KEY_SECOND);
      wait_evt(ts, 700);
      check_span("broken key", 508, 518, took);
      $display("test service key done");

      // reserved clock code never counts; rc may stop once deselected
      chip_reset(2);
      r0 = reset_seen;
      wr(`CTRL_ADDR, 8'h8F);
      rc_tick <= 1'b0;
      repeat (300) @(posedge aclk);
      check("reserved clock", r0, reset_seen);
      $display("test reserved clock done");

      // clock enable low freezes the count; rtc source, 128 ticks
      chip_reset(2);
      wr(`CTRL_ADDR, 8'h87);
      ts = cyc;
      ce <= 1'b0;
      repeat (200) @(posedge aclk);
      check("frozen", r0, reset_seen);
      ce <= 1'b1;
      wait_evt(ts, 500);
      check_span("frozen count", 326, 334, took);
      $display("test clock enable done");
      wrap_up();
   end

   // hard limit on the whole run
   initial begin
      #(40 * 90000);
      give_up("run length");
   end
endmodule
